// *** pcc_pwm.sv ***
// The address map and strobed register access were left to the implementer.
`timescale 1ns/100ps
module pcc_pwm #(
   parameter int CHANNELS = pcc_pkg::PCC_CHANNELS
) (
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          reset,
   // Register port
   input  wire logic [pcc_pkg::PCC_ADDR_W:0]  addr,
   input  wire logic [7:0]                    wdata,
   input  wire logic                          wr,
   input  wire logic                          rd,
   output logic [7:0]                         rdata_q,
   // Pins
   output logic [CHANNELS-1:0]                pin_out,
   output logic [CHANNELS-1:0]                pin_oe
);
   logic [7:0]          period_q, period_d;
   logic [7:0]          timer_q, timer_d;
   logic [1:0]          frac_q, frac_d;
   logic [7:0]          rdata_d;
   pcc_pkg::pcc_base_t  base;
   logic [7:0]          ctrl_rd [CHANNELS];
   logic [7:0]          dh      [CHANNELS];
   logic [1:0]          dl      [CHANNELS];
   logic [1:0]          reg_sel;
   logic                ch_sel;

   assign reg_sel = addr[1:0];
   assign ch_sel  = addr[2];

   // shared time base: two fraction bits extend the 8-bit timer
   always_comb begin
      frac_d   = frac_q + 2'h1;
      timer_d  = timer_q;
      period_d = period_q;
      if (frac_q == 2'h3) begin
         timer_d = (timer_q == period_q) ? 8'h00 : timer_q + 8'h01;
      end
      if (wr && reg_sel == pcc_pkg::PCC_REG_PERIOD && !addr[3]) begin
         period_d = wdata;
      end
   end

   assign base.timer   = timer_q;
   assign base.frac    = frac_q;
   assign base.match   = (timer_q == period_q);
   assign base.restart = base.match && frac_q == 2'h3;

   always_ff @(posedge clock) begin
      if (reset) begin
         timer_q  <= 8'h00;
         frac_q   <= pcc_pkg::PCC_PRESCALE_RST;
         period_q <= pcc_pkg::PCC_PERIOD_RST;
      end else begin
         timer_q  <= timer_d;
         frac_q   <= frac_d;
         period_q <= period_d;
      end
   end

   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      logic hit;
      assign hit = wr && !addr[3] && ch_sel == 1'(i);
      pcc_channel u_ch (
         .clock     (clock),
         .reset     (reset),
         .ctrl_we   (hit && reg_sel == pcc_pkg::PCC_REG_CTRL),
         .dh_we     (hit && reg_sel == pcc_pkg::PCC_REG_DUTY_H),
         .dl_we     (hit && reg_sel == pcc_pkg::PCC_REG_DUTY_L),
         .wdata     (wdata),
         .base      (base),
         .period    (period_q),
         .ctrl_rd   (ctrl_rd[i]),
         .dh_q      (dh[i]),
         .dl_q      (dl[i]),
         .pin_out_q (pin_out[i]),
         .pin_oe_q  (pin_oe[i])
      );
   end

   // Unmapped addresses read zero
   always_comb begin
      rdata_d = 8'h00;
      if (rd && !addr[3]) begin
         case (reg_sel)
            pcc_pkg::PCC_REG_CTRL:   rdata_d = ctrl_rd[ch_sel];
            pcc_pkg::PCC_REG_DUTY_H: rdata_d = dh[ch_sel];
            pcc_pkg::PCC_REG_DUTY_L: rdata_d = {dl[ch_sel], 6'h00};
            pcc_pkg::PCC_REG_PERIOD: rdata_d = period_q;
            default:                 rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   a_timer_wrap: assert property (@(posedge clock) disable iff (reset) base.restart |=> timer_q == 8'h00)
      else $error("timer did not restart");
   a_rd_zero: assert property (@(posedge clock) disable iff (reset) !$past(rd) |-> rdata_q == 8'h00)
      else $error("read data outside read cycle");
   c_restart: cover property (@(posedge clock) disable iff (reset) base.restart);
endmodule

// *** pcc_pkg.sv ***
// Functional notes
// - Control bit 7 enables the channel, bit 6 connects waveform to pin.
// - Control bit 5 is read-only and returns the live modulated output.
// - Control bit 4 set makes the output active-low, clear active-high.
// - Control bits 3 to 0 ignore writes and read as zero.
// - Duty high register holds the eight upper duty bits, read/write.
// - Duty low bits 7:6 hold two lower duty bits; bits 5:0 read zero.
// - Control bits reset to zero; duty registers keep value across reset.
// - Two identical channels with own registers share one timer and period.
// - Output goes active at timer restart, inactive when extended timer equals duty.
// - Duty at or above period value never clears the output.
// - Duty writes are buffered and take effect at timer-period match.
// - Zero duty keeps the output inactive at period start.
package pcc_pkg;
   localparam int          PCC_CHANNELS   = 2;
   localparam int          PCC_ADDR_W     = 3;
   // Register index: channel * 4 + register
   localparam logic [1:0]  PCC_REG_CTRL   = 2'h0;
   localparam logic [1:0]  PCC_REG_DUTY_H = 2'h1;
   localparam logic [1:0]  PCC_REG_DUTY_L = 2'h2;
   localparam logic [1:0]  PCC_REG_PERIOD = 2'h3;
   localparam int          PCC_BIT_EN     = 7;
   localparam int          PCC_BIT_OE     = 6;
   localparam int          PCC_BIT_OUT    = 5;
   localparam int          PCC_BIT_POL    = 4;
   localparam logic [7:0]  PCC_CTRL_RESET = 8'h00;
   localparam logic [7:0]  PCC_PERIOD_RST = 8'hff;
   localparam logic [1:0]  PCC_PRESCALE_RST = 2'h0;

   typedef struct packed {
      logic                    wr;
      logic                    rd;
      logic [PCC_ADDR_W-1:0]   addr;
      logic [7:0]              wdata;
   } pcc_bus_t;

   typedef struct packed {
      logic       restart;
      logic [7:0] timer;
      logic [1:0] frac;
      logic       match;
   } pcc_base_t;
endpackage

// *** pcc_channel.sv ***
`timescale 1ns/100ps
module pcc_channel (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              reset,
   // Register writes
   input  wire logic              ctrl_we,
   input  wire logic              dh_we,
   input  wire logic              dl_we,
   input  wire logic [7:0]        wdata,
   // Shared time base
   input  wire pcc_pkg::pcc_base_t base,
   input  wire logic [7:0]        period,
   // State
   output logic [7:0]             ctrl_rd,
   output logic [7:0]             dh_q,
   output logic [1:0]             dl_q,
   output logic                   pin_out_q,
   output logic                   pin_oe_q
);
   logic [3:0] ctrl_q, ctrl_d;
   logic [7:0] dh_d;
   logic [1:0] dl_d;
   logic [9:0] buf_q, buf_d;
   logic       wave_q, wave_d, pin_out_d, pin_oe_d;
   logic       en, oe, pol;

   assign en  = ctrl_q[3];
   assign oe  = ctrl_q[2];
   assign pol = ctrl_q[0];
   assign ctrl_rd = {ctrl_q[3:2], pin_out_q, ctrl_q[0], 4'h0};

   always_comb begin
      ctrl_d    = ctrl_q;
      dh_d      = dh_q;
      dl_d      = dl_q;
      buf_d     = buf_q;
      wave_d    = wave_q;
      if (ctrl_we) begin
         ctrl_d = {wdata[pcc_pkg::PCC_BIT_EN], wdata[pcc_pkg::PCC_BIT_OE], 1'b0, wdata[pcc_pkg::PCC_BIT_POL]};
      end
      if (dh_we) begin
         dh_d = wdata;
      end
      if (dl_we) begin
         dl_d = wdata[7:6];
      end
      if (!en) begin
         wave_d = 1'b0;
      end else if (base.restart) begin
         buf_d  = {dh_q, dl_q};
         wave_d = ({dh_q, dl_q} != 10'h000);
      end else if ({base.timer, base.frac} + 10'h001 == buf_q && buf_q[9:2] < period) begin
         // clear on match below period
         // Next time base is compared so the registered output is low in the matching count
         wave_d = 1'b0;
      end
      pin_out_d = wave_d ^ ctrl_d[0];
      // drive only while enabled and connected
      pin_oe_d  = ctrl_d[3] & ctrl_d[2];
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_q    <= 4'h0;
         wave_q    <= 1'b0;
         pin_out_q <= 1'b0;
         pin_oe_q  <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         wave_q    <= wave_d;
         pin_out_q <= pin_out_d;
         pin_oe_q  <= pin_oe_d;
      end
      dh_q  <= dh_d;
      dl_q  <= dl_d;
      buf_q <= buf_d;
   end

   // Assertions
   a_ctrl_low_zero: assert property (@(posedge clock) disable iff (reset) ctrl_rd[3:0] == 4'h0)
      else $error("control low bits not zero");
   a_oe_gate: assert property (@(posedge clock) disable iff (reset) pin_oe_q == (en && oe))
      else $error("pin driven while not enabled");
   a_pol_idle: assert property (@(posedge clock) disable iff (reset) !en && $past(!en) |-> pin_out_q == pol)
      else $error("disabled output not at inactive level");
   a_zero_duty: assert property (@(posedge clock) disable iff (reset)
      en && base.restart && {dh_q, dl_q} == 10'h000 && !ctrl_we |=> wave_q == 1'b0)
      else $error("zero duty went active");
   a_buf_load: assert property (@(posedge clock) disable iff (reset)
      en && base.restart |=> buf_q == $past({dh_q, dl_q}))
      else $error("duty buffer not loaded");
   a_dh_write: assert property (@(posedge clock) dh_we |=> dh_q == $past(wdata))
      else $error("duty high not written");
   c_active: cover property (@(posedge clock) disable iff (reset) en && !wave_q ##1 wave_q);
   c_clear: cover property (@(posedge clock) disable iff (reset) wave_q ##1 en && !wave_q);
   c_inverted: cover property (@(posedge clock) disable iff (reset) pin_oe_q && pol);
endmodule

// *** pcc_pin_model.sv ***
`timescale 1ns/100ps
module pcc_pin_model #(
   parameter int W = 2
) (
   // Channel drive
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe,
   // Board-side level
   output logic      [W-1:0] pin_level
);
   // Released pin pulled up
   // Pull-up keeps a released pin from reading as the last driven value
   always_comb pin_level = (pin_oe & pin_out) | ~pin_oe;
endmodule

// *** test_pcc_pwm.sv ***
`timescale 1ns/100ps
module test_pcc_pwm;
   logic       clock = 1'b0;
   logic       reset = 1'b1;
   logic [3:0] addr  = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr    = 1'b0;
   logic       rd    = 1'b0;
   logic [7:0] rdata_q;
   logic [1:0] pin_out;
   logic [1:0] pin_oe;
   logic [1:0] pin_level;
   int         errors  = 0;
   int         checked = 0;

   always #4 clock = ~clock;

   pcc_pwm dut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                .rdata_q(rdata_q), .pin_out(pin_out), .pin_oe(pin_oe));
   pcc_pin_model #(.W(2)) pin (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, seen);
         errors++;
      end
   endtask

   // Called right after a rising edge; leaves one edge idle so strobes never collide
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd_reg(input string name, input logic [3:0] a, input logic [7:0] exp);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      @(negedge clock);
      check(name, rdata_q, exp);
      @(posedge clock);
   endtask

   // Four whole periods of 16 clocks each, so any phase gives the same count
   task automatic high_count(input string name, input int ch, input logic [7:0] exp);
      logic [7:0] n;
      n = 8'h00;
      repeat (40) @(posedge clock);
      repeat (64) begin
         @(negedge clock);
         if (pin_level[ch] === 1'b1) n = n + 8'h01;
      end
      check(name, n, exp);
      @(posedge clock);
   endtask

   task automatic stop_test;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #160000;
      errors++;
      stop_test();
   end

   initial begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rd_reg("ctrl0 reset", 4'h0, 8'h00);
      rd_reg("ctrl1 reset", 4'h4, 8'h00);
      rd_reg("unmapped", 4'h8, 8'h00);
      wr_reg(4'h8, 8'hff);
      rd_reg("ctrl0 after unmapped", 4'h0, 8'h00);
      rd_reg("period reset", 4'h3, 8'hff);
      // Live bit ignores writes
      wr_reg(4'h0, 8'h2f);
      rd_reg("ctrl0 live ro", 4'h0, 8'h00);
      // Disabled channel shows polarity level on the live bit
      wr_reg(4'h0, 8'h3f);
      rd_reg("ctrl0 pol", 4'h0, 8'h30);
      check("pin_oe off", {6'h00, pin_oe}, 8'h00);
      for (int c = 0; c < 2; c++) begin
         wr_reg(4'(c * 4 + 1), 8'ha5 ^ 8'(c));
         wr_reg(4'(c * 4 + 2), 8'hff ^ 8'(c * 8'h40));
      end
      for (int c = 0; c < 2; c++) begin
         rd_reg("duty high", 4'(c * 4 + 1), 8'ha5 ^ 8'(c));
         rd_reg("duty low", 4'(c * 4 + 2), 8'hc0 ^ 8'(c * 8'h40));
      end
      reset <= 1'b1;
      @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rd_reg("ctrl0 rereset", 4'h0, 8'h00);
      rd_reg("duty kept", 4'h1, 8'ha5);
      rd_reg("duty low kept", 4'h6, 8'h80);
      // Period 3 gives 16 clocks per period at 4 clocks per timer step
      wr_reg(4'h3, 8'h03);
      rd_reg("period shared", 4'h7, 8'h03);
      wr_reg(4'h1, 8'h01);
      wr_reg(4'h2, 8'h80);
      wr_reg(4'h5, 8'h00);
      wr_reg(4'h6, 8'h00);
      wr_reg(4'h0, 8'hc0);
      wr_reg(4'h4, 8'hc0);
      check("pin_oe on", {6'h00, pin_oe}, 8'h03);
      high_count("ch0 duty 6", 0, 8'd24);
      high_count("ch1 duty 0", 1, 8'd0);
      wr_reg(4'h5, 8'h03);
      high_count("ch1 full", 1, 8'd64);
      wr_reg(4'h0, 8'hd0);
      high_count("ch0 inverted", 0, 8'd40);
      wr_reg(4'h0, 8'h90);
      check("pin_oe ch0 off", {6'h00, pin_oe}, 8'h02);
      high_count("ch0 released", 0, 8'd64);
      high_count("ch1 untouched", 1, 8'd64);
      stop_test();
   end
endmodule
